/* hw/tmc_core.sv */
`timescale 1ns/1ps
// Behaviour
// (RL1) Compare match interrupts, may clear and drive output
// (RL2) Three-bit field picks counter clock source
// (RL3) Separate interrupt sources for comparators A, P
// (RL4) External pin used only when selected, edge chosen
// (RL5) Each active external edge advances the counter
// (RL6) Capture edge rising, falling or both selectable
// (RL7) Compare mode sets, clears or toggles outputs
// (RL8) PWM waveform appears on primary output pin
// (RL9) Per-pin select bit enables timer function
// (RL10) Low bytes only via shared buffer
// (RL11) Compare low write loads only buffer
// (RL12) Compare high write copies buffer to low
// (RL13) High read latches low byte into buffer
// (RL14) Low read returns buffer contents
// (RL15) Software writes low first, reads high first
// (RL16) Ten-bit up-counter on selected source
// (RL17) P compares top three bits, A all ten
// (RL18) Counter cleared by on-bit rise, overflow, match
// (RL19) Increment once per synchronised active source edge; the low-clock input counts unsynchronised, every cycle it is high
module tmc_core #(
  parameter int ADDR_W = 8  // APB address width
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              internal_high_clock,
  input  wire logic              internal_low_clock,
  input  wire logic              timer_ext_clock_pin,
  input  wire logic              capture_input_pin,
  output logic                   timer_output_pin,
  output logic                   timer_output_pin_oe,
  output logic                   timer_output_inv_pin,
  output logic                   timer_output_inv_pin_oe,
  output logic                   irq
);

  tmc_pkg::tmc_ctrl0_s          ctrl0_reg;      // Clock, on, pause, period
  tmc_pkg::tmc_ctrl1_s          ctrl1_reg;      // Mode, edge/action, polarity
  logic [9:0]                   count_reg;      // Main up-counter
  logic [9:0]                   cmp_a_reg;      // Comparator A value
  logic [7:0]                   buf_reg;        // Shared low-byte buffer
  logic                         on_d_reg;       // Delayed on bit for edge
  logic [1:0]                   sys_div_reg;    // System clock divide by four
  logic [5:0]                   hi_div_reg;     // High clock prescaler
  logic                         out_reg;        // Timer output state
  logic [tmc_pkg::INT_W-1:0]    status_reg;     // Sticky events
  logic [tmc_pkg::INT_W-1:0]    enable_reg;     // Interrupt enables
  logic [tmc_pkg::PIN_W-1:0]    pin_share_reg;  // Pin function selects
  logic [31:0]                  prdata_next;    // Read data for next cycle
  logic                         tick;           // Counter advance strobe
  logic                         on_rise;        // Counter-on low-to-high
  logic                         run;            // Counting permitted
  logic [10:0]                  inc;            // Count plus one, with carry
  logic                         a_hit;          // Comparator A match
  logic                         p_hit;          // Comparator P match or overflow
  logic                         clr_hit;        // Match that clears counter
  logic                         cap_hit;        // Selected capture edge seen
  logic                         setup;          // APB setup phase
  logic                         access;         // APB access phase
  logic                         wr;             // Write taking effect
  logic                         rd;             // Read taking effect
  logic [1:0]                   pin_rise;       // Synchronised rising edges
  logic [1:0]                   pin_fall;       // Synchronised falling edges
  logic [1:0]                   pins;           // Raw pins, ext clock then capture

  // Mapped address check
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_W'(tmc_pkg::OFS_CTRL0)) || (a == ADDR_W'(tmc_pkg::OFS_CTRL1))
             || (a == ADDR_W'(tmc_pkg::OFS_COUNT_LOW)) || (a == ADDR_W'(tmc_pkg::OFS_COUNT_HIGH))
             || (a == ADDR_W'(tmc_pkg::OFS_CMPA_LOW)) || (a == ADDR_W'(tmc_pkg::OFS_CMPA_HIGH))
             || (a == ADDR_W'(tmc_pkg::OFS_INT_STATUS)) || (a == ADDR_W'(tmc_pkg::OFS_INT_CLEAR))
             || (a == ADDR_W'(tmc_pkg::OFS_INT_ENABLE)) || (a == ADDR_W'(tmc_pkg::OFS_PIN_SHARE));
  endfunction

  // Capture edge decode from the two function bits
  function automatic logic cap_edge(input logic [1:0] sel, input logic r, input logic f);
    unique case (sel)
      2'h0:    cap_edge = r;
      2'h1:    cap_edge = f;
      2'h2:    cap_edge = r | f;
      default: cap_edge = 1'b0;
    endcase
  endfunction

  assign pins   = {capture_input_pin, timer_ext_clock_pin};
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr     = ce & access & pwrite;
  assign rd     = ce & access & ~pwrite;

  // Both outside pins pass the same three-flop synchroniser
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      tmc_sync u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (pins[g]),
        .rise  (pin_rise[g]),
        .fall  (pin_fall[g])
      );
    end
  endgenerate

  // Clock source selection; pin edges count only when the pin is shared in
  always_comb begin
    unique case (ctrl0_reg.clock_select_field)  // [RL2]
      tmc_pkg::CK_SYS_DIV4: tick = (sys_div_reg == tmc_pkg::SYS_DIV4_LAST);
      tmc_pkg::CK_SYS:      tick = 1'b1;
      tmc_pkg::CK_HI_DIV16: tick = internal_high_clock
                                   && (hi_div_reg[3:0] == tmc_pkg::HI_DIV16_LAST[3:0]);
      tmc_pkg::CK_HI_DIV64: tick = internal_high_clock && (hi_div_reg == tmc_pkg::HI_DIV64_LAST);
      tmc_pkg::CK_LOW_A,
      tmc_pkg::CK_LOW_B:    tick = internal_low_clock;
      tmc_pkg::CK_EXT_RISE: tick = pin_share_reg[tmc_pkg::PIN_EXT_CLK] & pin_rise[0]; // [RL4] [RL5]
      tmc_pkg::CK_EXT_FALL: tick = pin_share_reg[tmc_pkg::PIN_EXT_CLK] & pin_fall[0]; // [RL4] [RL5]
    endcase
  end

  // Prescalers run freely so a source switch needs no resync
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sys_div_reg <= 2'h0;
      hi_div_reg  <= 6'h00;
    end else if (ce) begin
      sys_div_reg <= sys_div_reg + 2'h1;
      if (internal_high_clock) begin
        hi_div_reg <= hi_div_reg + 6'h01;
      end
    end
  end

  // Match detection looks at the value the counter is about to take
  assign inc     = {1'b0, count_reg} + 11'h001;
  assign p_hit   = (ctrl0_reg.period_compare_value == 3'h0) ? inc[10]
                 : (inc[9:7] == ctrl0_reg.period_compare_value) && (inc[6:0] == 7'h00); // [RL17]
  assign a_hit   = !inc[10] && (inc[9:0] == cmp_a_reg);                               // [RL17]
  assign clr_hit = ctrl1_reg.clear_on_a ? a_hit : p_hit;
  assign on_rise = ctrl0_reg.counter_on_bit & ~on_d_reg;
  assign run     = ctrl0_reg.counter_on_bit & ~ctrl0_reg.pause & tick;
  assign cap_hit = (ctrl1_reg.mode == tmc_pkg::MODE_CAPTURE) && pin_share_reg[tmc_pkg::PIN_CAPTURE]
                 && cap_edge({ctrl1_reg.pin_function_sel_hi, ctrl1_reg.pin_function_sel_lo},
                             pin_rise[1], pin_fall[1]);                               // [RL6]

  // Ten-bit up-counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= tmc_pkg::RST_WORD;
      on_d_reg  <= 1'b0;
    end else if (ce) begin
      on_d_reg <= ctrl0_reg.counter_on_bit;
      if (on_rise) begin
        count_reg <= tmc_pkg::RST_WORD;       // [RL18]
      end else if (run) begin
        if (clr_hit) begin
          count_reg <= tmc_pkg::RST_WORD;     // [RL18] [RL1]
        end else begin
          count_reg <= inc[9:0];              // [RL16] [RL19]
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl0_reg     <= tmc_pkg::tmc_ctrl0_s'(tmc_pkg::RST_BYTE);
      ctrl1_reg     <= tmc_pkg::tmc_ctrl1_s'(tmc_pkg::RST_BYTE);
      enable_reg    <= '0;
      pin_share_reg <= '0;
    end else if (wr) begin
      if (paddr == ADDR_W'(tmc_pkg::OFS_CTRL0)) begin
        ctrl0_reg <= tmc_pkg::tmc_ctrl0_s'(pwdata[7:0]);
      end
      if (paddr == ADDR_W'(tmc_pkg::OFS_CTRL1)) begin
        ctrl1_reg <= tmc_pkg::tmc_ctrl1_s'(pwdata[7:0]);
      end
      if (paddr == ADDR_W'(tmc_pkg::OFS_INT_ENABLE)) begin
        enable_reg <= pwdata[tmc_pkg::INT_W-1:0];
      end
      if (paddr == ADDR_W'(tmc_pkg::OFS_PIN_SHARE)) begin
        pin_share_reg <= pwdata[tmc_pkg::PIN_W-1:0];
      end
    end
  end

  // Comparator A and the shared low-byte buffer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmp_a_reg <= tmc_pkg::RST_WORD;
      buf_reg   <= tmc_pkg::RST_BYTE;
    end else if (ce) begin
      if (wr && paddr == ADDR_W'(tmc_pkg::OFS_CMPA_LOW)) begin
        buf_reg <= pwdata[7:0];                     // [RL10] [RL11]
      end else if (wr && paddr == ADDR_W'(tmc_pkg::OFS_CMPA_HIGH)) begin
        cmp_a_reg <= {pwdata[1:0], buf_reg};        // [RL10] [RL12]
      end else if (rd && paddr == ADDR_W'(tmc_pkg::OFS_COUNT_HIGH)) begin
        buf_reg <= count_reg[7:0];                  // [RL13]
      end else if (rd && paddr == ADDR_W'(tmc_pkg::OFS_CMPA_HIGH)) begin
        buf_reg <= cmp_a_reg[7:0];                  // [RL13]
      end else if (cap_hit) begin
        // Capture loses to a comparator A write or a high-byte read in the same cycle; rare, and software owns it
        cmp_a_reg <= count_reg;
      end
    end
  end

  // Output state: initial level on start, match actions, PWM duty
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else if (ce) begin
      if (on_rise) begin
        out_reg <= ctrl1_reg.out_init;
      end else if (ctrl1_reg.mode == tmc_pkg::MODE_COMPARE) begin
        if (run && a_hit) begin
          unique case ({ctrl1_reg.pin_function_sel_hi, ctrl1_reg.pin_function_sel_lo}) // [RL7]
            2'h0: out_reg <= out_reg;
            2'h1: out_reg <= 1'b0;
            2'h2: out_reg <= 1'b1;
            2'h3: out_reg <= ~out_reg;
          endcase
        end
      end else if (ctrl1_reg.mode == tmc_pkg::MODE_PWM) begin
        unique case ({ctrl1_reg.pin_function_sel_hi, ctrl1_reg.pin_function_sel_lo})
          2'h0: out_reg <= 1'b0;
          2'h1: out_reg <= 1'b1;
          default: out_reg <= ctrl0_reg.counter_on_bit && (count_reg < cmp_a_reg); // [RL8]
        endcase
      end
    end
  end

  // Pins carry the timer function only when their select bit is set
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_output_pin        <= 1'b0;
      timer_output_pin_oe     <= 1'b0;
      timer_output_inv_pin    <= 1'b0;
      timer_output_inv_pin_oe <= 1'b0;
    end else if (ce) begin
      timer_output_pin_oe     <= pin_share_reg[tmc_pkg::PIN_OUT];                    // [RL9]
      timer_output_inv_pin_oe <= pin_share_reg[tmc_pkg::PIN_OUT_INV];                // [RL9]
      timer_output_pin        <= pin_share_reg[tmc_pkg::PIN_OUT]
                                 & (out_reg ^ ctrl1_reg.out_pol);                    // [RL8]
      timer_output_inv_pin    <= pin_share_reg[tmc_pkg::PIN_OUT_INV]
                                 & ~(out_reg ^ ctrl1_reg.out_pol);
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_reg <= '0;
    end else if (ce) begin
      status_reg <= (status_reg & ~((wr && paddr == ADDR_W'(tmc_pkg::OFS_INT_CLEAR))
                                    ? pwdata[tmc_pkg::INT_W-1:0] : '0))
                  | {cap_hit, run & p_hit, run & a_hit};                             // [RL3] [RL1]
    end
  end

  // Level interrupt from enabled sticky bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status_reg & enable_reg);                                             // [RL1]
    end
  end

  // Read data mux; low bytes come from the buffer, never live
  always_comb begin
    prdata_next = 32'h0000_0000;
    unique case (paddr)
      ADDR_W'(tmc_pkg::OFS_CTRL0):      prdata_next[7:0] = ctrl0_reg;
      ADDR_W'(tmc_pkg::OFS_CTRL1):      prdata_next[7:0] = ctrl1_reg;
      ADDR_W'(tmc_pkg::OFS_COUNT_LOW):  prdata_next[7:0] = buf_reg;                  // [RL14]
      ADDR_W'(tmc_pkg::OFS_CMPA_LOW):   prdata_next[7:0] = buf_reg;                  // [RL14]
      ADDR_W'(tmc_pkg::OFS_COUNT_HIGH): prdata_next[1:0] = count_reg[9:8];           // [RL10]
      ADDR_W'(tmc_pkg::OFS_CMPA_HIGH):  prdata_next[1:0] = cmp_a_reg[9:8];           // [RL10]
      ADDR_W'(tmc_pkg::OFS_INT_STATUS): prdata_next[tmc_pkg::INT_W-1:0] = status_reg;
      ADDR_W'(tmc_pkg::OFS_INT_ENABLE): prdata_next[tmc_pkg::INT_W-1:0] = enable_reg;
      ADDR_W'(tmc_pkg::OFS_PIN_SHARE):  prdata_next[tmc_pkg::PIN_W-1:0] = pin_share_reg;
      default:                          prdata_next = 32'h0000_0000;
    endcase
  end

  // APB answer registered in setup, so every access takes one wait-free phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~is_mapped(paddr);
      if (setup && !pwrite) begin
        prdata <= prdata_next;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_on_start;
    ce && on_rise;
  endsequence

  property p_on_clear;
    s_on_start |=> (count_reg == 10'h000);
  endproperty
  a_on_clear: assert property (p_on_clear) else $error("counter not cleared on start"); // [RL18]

  property p_flag_a;
    ce && run && a_hit |=> status_reg[tmc_pkg::INT_MATCH_A] ##1 irq || !enable_reg[0];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("match A event lost");   // [RL3]

  property p_flag_p;
    ce && run && p_hit |=> status_reg[tmc_pkg::INT_MATCH_P];
  endproperty
  a_flag_p: assert property (p_flag_p) else $error("match P event lost");   // [RL3]

  property p_count_inc;
    ce && run && !clr_hit && !on_rise |=> count_reg == $past(count_reg) + 10'h001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter did not step"); // [RL19]

  property p_clear_match;
    ce && run && clr_hit && !on_rise |=> count_reg == 10'h000;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("match did not clear"); // [RL1]

  property p_wr_low;
    wr && paddr == ADDR_W'(tmc_pkg::OFS_CMPA_LOW)
      |=> cmp_a_reg == $past(cmp_a_reg) && buf_reg == $past(pwdata[7:0]);
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low write touched compare"); // [RL11]

  property p_wr_high;
    wr && paddr == ADDR_W'(tmc_pkg::OFS_CMPA_HIGH)
      |=> cmp_a_reg == {$past(pwdata[1:0]), $past(buf_reg)};
  endproperty
  a_wr_high: assert property (p_wr_high) else $error("high write lost buffer"); // [RL12]

  property p_rd_high;
    rd && paddr == ADDR_W'(tmc_pkg::OFS_COUNT_HIGH) |=> buf_reg == $past(count_reg[7:0]);
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("high read did not latch"); // [RL13]

  property p_rd_low;
    ce && setup && !pwrite && paddr == ADDR_W'(tmc_pkg::OFS_CMPA_LOW)
      |=> prdata == {24'h000000, $past(buf_reg)};
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low read not from buffer"); // [RL14]

  property p_cmp_high;
    ce && run && a_hit && !on_rise && ctrl1_reg.mode == tmc_pkg::MODE_COMPARE
      && {ctrl1_reg.pin_function_sel_hi, ctrl1_reg.pin_function_sel_lo} == 2'h2 |=> out_reg;
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("match did not set output"); // [RL7]

  property p_pin_gate;
    ce ##1 !$past(pin_share_reg[tmc_pkg::PIN_OUT]) |-> !timer_output_pin && !timer_output_pin_oe;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("output driven unselected"); // [RL9]

  property p_ext_gate;
    ctrl0_reg.clock_select_field == tmc_pkg::CK_EXT_RISE
      && !pin_share_reg[tmc_pkg::PIN_EXT_CLK] |-> !tick;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("unselected pin clocked"); // [RL4]

endmodule

/* hw/tmc_pkg.sv */
package tmc_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_CTRL0      = 8'h00;
  localparam logic [7:0] OFS_CTRL1      = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW  = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CMPA_LOW   = 8'h10;
  localparam logic [7:0] OFS_CMPA_HIGH  = 8'h14;
  localparam logic [7:0] OFS_INT_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_CLEAR  = 8'h1C;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h20;
  localparam logic [7:0] OFS_PIN_SHARE  = 8'h24;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_WORD = 10'h000;

  // Interrupt status bit positions
  localparam int INT_MATCH_A = 0;
  localparam int INT_MATCH_P = 1;
  localparam int INT_CAPTURE = 2;
  localparam int INT_W       = 3;

  // Pin-share bit positions
  localparam int PIN_EXT_CLK = 0;
  localparam int PIN_CAPTURE = 1;
  localparam int PIN_OUT     = 2;
  localparam int PIN_OUT_INV = 3;
  localparam int PIN_W       = 4;

  // Prescaler terminal counts
  localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
  localparam logic [5:0] HI_DIV16_LAST = 6'h0F;
  localparam logic [5:0] HI_DIV64_LAST = 6'h3F;

  // Counter clock sources
  typedef enum logic [2:0] {
    CK_SYS_DIV4, CK_SYS, CK_HI_DIV16, CK_HI_DIV64,
    CK_LOW_A, CK_LOW_B, CK_EXT_RISE, CK_EXT_FALL
  } tmc_clk_sel_e;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER
  } tmc_mode_e;

  // First control register layout
  typedef struct packed {
    logic         pause;
    tmc_clk_sel_e clock_select_field;
    logic         counter_on_bit;
    logic [2:0]   period_compare_value;
  } tmc_ctrl0_s;

  // Second control register layout
  typedef struct packed {
    tmc_mode_e mode;
    logic      pin_function_sel_hi;
    logic      pin_function_sel_lo;
    logic      out_init;
    logic      out_pol;
    logic      dpx;
    logic      clear_on_a;
  } tmc_ctrl1_s;

endpackage

/* hw/tmc_sync.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser with agreed edge pulses
module tmc_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic s1_reg;  // Metastability catcher, read only by s2
  logic s2_reg;  // Second stage
  logic s3_reg;  // Third stage, compared with the second
  logic lvl_reg; // Level that stages two and three last agreed on
  logic agree;   // Stages two and three hold the same value

  // Shift the pin through three flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Only an agreed level moves the reference, so a one-cycle glitch is ignored
      if (agree) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  // A change counts once stages two and three agree on it
  assign agree = (s2_reg == s3_reg);
  assign rise  = agree & s3_reg & ~lvl_reg;
  assign fall  = agree & ~s3_reg & lvl_reg;

endmodule

/* sim/tmc_pins.sv */
`timescale 1ns/1ps
// Far-side pins: external count clock and capture input
module tmc_pins (
  input  wire logic clock,
  output logic      ext_clk,
  output logic      cap
);
  // Both pins idle low, so no stray edge reaches the timer between bursts
  initial begin
    ext_clk = 1'b0;
    cap     = 1'b0;
  end
  // Each level held 4 cycles so the three-flop synchroniser agrees on it
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  // One capture level change, then settle time for the edge detector
  task automatic set_cap(input logic v);
    @(posedge clock);
    cap <= v;
    repeat (8) @(posedge clock);
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench: registers over APB, pins through the partner
module tb_top;
  logic        clock = 1'b0;   // 200 MHz system clock
  logic        rst_n = 1'b0;   // Synchronous reset, low active
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic        pready, pslverr, err, ext_clk, cap, irq;
  logic        out_pin, out_oe, inv_pin, inv_oe;
  logic        ce = 1'b1, hclk = 1'b0, lclk = 1'b0;  // Enable and tick inputs
  int          n_fail = 0, total_checks = 0;

  always #2.5 clock = ~clock;

  // Clock enable and tick inputs are driven by the scenarios that need them
  tmc_core tmc_core_i (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_high_clock(hclk), .internal_low_clock(lclk),
    .timer_ext_clock_pin(ext_clk), .capture_input_pin(cap),
    .timer_output_pin(out_pin), .timer_output_pin_oe(out_oe),
    .timer_output_inv_pin(inv_pin), .timer_output_inv_pin_oe(inv_oe), .irq(irq));
  tmc_pins tmc_pins_i (.clock(clock), .ext_clk(ext_clk), .cap(cap));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a ten-bit pair: high byte first, then the buffered low byte
  task automatic rd_pair(input logic [7:0] ha, input logic [7:0] la, input logic [9:0] exp);
    apb(1'b0, ha, 32'h0);
    chk(q, {30'h0, exp[9:8]});
    apb(1'b0, la, 32'h0);
    chk(q, {24'h0, exp[7:0]});
  endtask

  // Drive the high or low tick input for n consecutive cycles
  task automatic ticks(input logic hi, input int n);
    @(posedge clock);
    if (hi) hclk <= 1'b1;
    else lclk <= 1'b1;
    repeat (n) @(posedge clock);
    hclk <= 1'b0;
    lclk <= 1'b0;
  endtask

  // Reset values and an unmapped address
  task automatic t_reset();
    apb(1'b0, tmc_pkg::OFS_CTRL0, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, tmc_pkg::OFS_INT_STATUS, 32'h0);
    chk(q, 32'h0);
    chk({30'h0, inv_oe, out_oe}, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  // Low byte goes through the buffer; high access moves it
  task automatic t_buffer();
    apb(1'b1, tmc_pkg::OFS_CMPA_LOW, 32'h5A);
    apb(1'b0, tmc_pkg::OFS_CMPA_HIGH, 32'h0);
    apb(1'b0, tmc_pkg::OFS_CMPA_LOW, 32'h0);
    chk(q, 32'h00);
    apb(1'b1, tmc_pkg::OFS_CMPA_LOW, 32'h5A);
    apb(1'b1, tmc_pkg::OFS_CMPA_HIGH, 32'h1);
    apb(1'b0, tmc_pkg::OFS_CMPA_HIGH, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, tmc_pkg::OFS_CMPA_LOW, 32'h0);
    chk(q, 32'h5A);
  endtask

  // Comparator A match at 346: interrupt, toggle, clear and mask
  task automatic t_match_a();
    int n;
    apb(1'b1, tmc_pkg::OFS_CTRL1, 32'h31);
    apb(1'b1, tmc_pkg::OFS_PIN_SHARE, 32'h0C);
    apb(1'b1, tmc_pkg::OFS_INT_ENABLE, 32'h1);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h18);
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    repeat (3) @(posedge clock);
    chk({28'h0, inv_oe, inv_pin, out_oe, out_pin}, 32'hB);
    apb(1'b0, tmc_pkg::OFS_INT_STATUS, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, tmc_pkg::OFS_INT_ENABLE, 32'h0);
    apb(1'b1, tmc_pkg::OFS_INT_CLEAR, 32'h7);
    repeat (400) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, tmc_pkg::OFS_INT_STATUS, 32'h0);
    chk(q, 32'h1);
  endtask

  // Period 1 clears at 128, so A at 346 is never reached
  task automatic t_match_p();
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h00);
    apb(1'b1, tmc_pkg::OFS_CTRL1, 32'h00);
    apb(1'b1, tmc_pkg::OFS_INT_CLEAR, 32'h7);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h19);
    repeat (400) @(posedge clock);
    apb(1'b0, tmc_pkg::OFS_INT_STATUS, 32'h0);
    chk(q, 32'h2);
  endtask

  // Five rising external edges give a count of exactly five
  task automatic t_ext();
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h00);
    apb(1'b1, tmc_pkg::OFS_CTRL1, 32'h01);
    apb(1'b1, tmc_pkg::OFS_PIN_SHARE, 32'h05);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h68);
    tmc_pins_i.ext_pulses(5);
    repeat (8) @(posedge clock);
    rd_pair(tmc_pkg::OFS_COUNT_HIGH, tmc_pkg::OFS_COUNT_LOW, 10'h005);
  endtask

  // Capture on rising only, then on falling only
  task automatic t_capture();
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h00);
    apb(1'b1, tmc_pkg::OFS_CTRL1, 32'h40);
    apb(1'b1, tmc_pkg::OFS_PIN_SHARE, 32'h02);
    apb(1'b1, tmc_pkg::OFS_INT_CLEAR, 32'h7);
    tmc_pins_i.set_cap(1'b1);
    apb(1'b0, tmc_pkg::OFS_INT_STATUS, 32'h0);
    chk(q, 32'h4);
    apb(1'b1, tmc_pkg::OFS_INT_CLEAR, 32'h7);
    tmc_pins_i.set_cap(1'b0);
    apb(1'b0, tmc_pkg::OFS_INT_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, tmc_pkg::OFS_CTRL1, 32'h50);
    tmc_pins_i.set_cap(1'b1);
    tmc_pins_i.set_cap(1'b0);
    apb(1'b0, tmc_pkg::OFS_INT_STATUS, 32'h0);
    chk(q, 32'h4);
    rd_pair(tmc_pkg::OFS_CMPA_HIGH, tmc_pkg::OFS_CMPA_LOW, 10'h005);
  endtask

  // High/16, high/64, low ticks, pause and clock enable; PWM level from count
  task automatic t_sources();
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h00);
    apb(1'b1, tmc_pkg::OFS_CTRL1, 32'hA0);
    apb(1'b1, tmc_pkg::OFS_PIN_SHARE, 32'h04);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h28);
    ticks(1'b1, 64);
    chk({30'h0, out_oe, out_pin}, 32'h3);
    rd_pair(tmc_pkg::OFS_COUNT_HIGH, tmc_pkg::OFS_COUNT_LOW, 10'h004);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h38);
    ticks(1'b1, 64);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h48);
    ticks(1'b0, 3);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'hC8);
    ticks(1'b0, 3);
    apb(1'b1, tmc_pkg::OFS_CTRL0, 32'h58);
    @(posedge clock);
    ce <= 1'b0;
    lclk <= 1'b1;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    lclk <= 1'b0;
    rd_pair(tmc_pkg::OFS_COUNT_HIGH, tmc_pkg::OFS_COUNT_LOW, 10'h008);
    chk({30'h0, out_oe, out_pin}, 32'h2);
  endtask

  // Main sequence after three reset cycles
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_buffer();
    t_match_a();
    t_match_p();
    t_ext();
    t_capture();
    t_sources();
    tally_and_finish();
  end

  // Watchdog well beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
endmodule
